// *** src/sfml_device_end.sv ***
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sfml_device_end #(
   parameter int NUM_LOCKS = sfml_pkg::NUM_LOCKS,
   parameter int RESET_CYCLES = sfml_pkg::RESET_CYCLES
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   sfml_link_if.dev link,
   input wire logic quadEnableBit,
   input wire logic protectSchemeSelect,
   input wire logic protectComplementBit,
   input wire logic sectorGranularityBit,
   input wire logic topBottomSelect,
   input wire logic [2:0] blockProtectField,
   input wire logic [sfml_pkg::ADDR_BITS-1:0] protAddr,
   output logic protActive,
   output logic fourWireMode,
   output logic writeEnableLatch,
   output logic suspendFlag,
   output logic resetBusy
);
   import sfml_pkg::*;

   localparam int LOCK_IDX_BITS = $clog2(NUM_LOCKS);
   localparam int BUSY_BITS = $clog2(RESET_CYCLES + 1);

   function automatic sfml_phase_type cmdPhase(input logic [7:0] op, input logic four_wire_command_mode);
      case (op)
         OP_WRAP_READ: cmdPhase = four_wire_command_mode ? PH_ADDR : PH_DROP;
         OP_SET_PARAM: cmdPhase = four_wire_command_mode ? PH_PARAM : PH_DROP;
         OP_LOCK, OP_UNLOCK, OP_READ_LOCK: cmdPhase = PH_ADDR;
         OP_ENTER_4W: cmdPhase = four_wire_command_mode ? PH_DROP : PH_TAIL;
         OP_EXIT_4W: cmdPhase = four_wire_command_mode ? PH_TAIL : PH_DROP;
         OP_WREN, OP_WRDI, OP_GLOBAL_LOCK, OP_GLOBAL_UNLOCK, OP_RESET_EN, OP_RESET,
         OP_SUSPEND, OP_RESUME: cmdPhase = PH_TAIL;
         default: cmdPhase = PH_DROP;
      endcase
   endfunction : cmdPhase

   function automatic logic [LOCK_IDX_BITS-1:0] lockIdx(input logic [ADDR_BITS-1:0] a);
      return a[BLOCK_LSB +: LOCK_IDX_BITS];
   endfunction : lockIdx

   function automatic logic legacyProt(input logic [ADDR_BITS-1:0] a, input logic [2:0] bp,
                                       input logic tb, input logic sec, input logic cmp);
      logic [6:0] n;
      logic [6:0] blk;
      logic [6:0] sct;
      logic hit;
      n = (bp == 3'h0) ? 7'h00 : 7'(7'h01 << (bp - 3'h1));
      blk = 7'(a[BLOCK_LSB +: BLOCK_BITS]);
      sct = 7'(a[SECTOR_LSB +: SECTOR_BITS]);
      if (tb) begin
         hit = sec ? (blk == 7'h00 && sct < n) : (blk < n);
      end else begin
         hit = sec ? (blk == NUM_BLOCKS - 7'h01 && sct + n >= SECTORS_PER_BLOCK)
                   : (blk + n >= NUM_BLOCKS);
      end
      return hit ^ cmp;
   endfunction : legacyProt

   // pin synchronisers
   logic [1:0] csSync_r;
   logic [1:0] sclkSync_r;
   logic [3:0] ioMeta_r;
   logic [3:0] ioSync_r;
   logic csDly_r;
   logic sclkDly_r;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         csSync_r <= 2'h3;
         sclkSync_r <= 2'h0;
         ioMeta_r <= 4'hf;
         ioSync_r <= 4'hf;
         csDly_r <= 1'b1;
         sclkDly_r <= 1'b0;
      end else begin
         csSync_r <= {csSync_r[0], link.csN};
         sclkSync_r <= {sclkSync_r[0], link.sclk};
         ioMeta_r <= link.ioLevel;
         ioSync_r <= ioMeta_r;
         csDly_r <= csSync_r[1];
         sclkDly_r <= sclkSync_r[1];
      end
   end

   logic csLow;
   logic csRise;
   logic sclkRise;
   logic sclkFall;
   assign csLow = ~csSync_r[1];
   assign csRise = csSync_r[1] & ~csDly_r;
   assign sclkRise = csLow & sclkSync_r[1] & ~sclkDly_r;
   assign sclkFall = csLow & ~sclkSync_r[1] & sclkDly_r;

   // configuration and lock state
   logic qpi_r;
   logic wel_r;
   logic susp_r;
   logic rstEn_r;
   logic [PARAM_BITS-1:0] param_r;
   logic [NUM_LOCKS-1:0] lock_r;
   logic [BUSY_BITS-1:0] busyCnt_r;

   // frame engine state
   sfml_phase_type phase_r;
   logic [5:0] fieldCnt_r;
   logic [ADDR_BITS-1:0] shift_r;
   logic [7:0] op_r;
   logic [ADDR_BITS-1:0] addr_r;
   logic [7:0] tx_r;
   logic [3:0] outCnt_r;
   logic [3:0] dummyCnt_r;
   logic complete_r;
   logic opSeen_r;

   logic busy;
   logic [2:0] stepBits;
   logic [ADDR_BITS-1:0] shiftNxt;
   logic [5:0] cntNxt;
   logic [3:0] outNxt;
   logic [1:0] wrapSel;
   logic [ADDR_BITS-1:0] addrNxt;
   logic softReset;
   sfml_phase_type opPhase;

   assign busy = (busyCnt_r != '0);
   assign stepBits = qpi_r ? 3'h4 : 3'h1;
   assign shiftNxt = qpi_r ? {shift_r[ADDR_BITS-5:0], ioSync_r}
                           : {shift_r[ADDR_BITS-2:0], ioSync_r[0]};
   assign cntNxt = fieldCnt_r + 6'(stepBits);
   assign outNxt = outCnt_r + 4'(stepBits);
   assign wrapSel = param_r[PARAM_WRAP_LSB +: 2];
   assign addrNxt = sfmlWrapNext(addr_r, wrapSel);
   assign opPhase = cmdPhase(shiftNxt[7:0], qpi_r);
   assign softReset = csRise & complete_r & rstEn_r & (op_r == OP_RESET);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         phase_r <= PH_CMD;
         fieldCnt_r <= 6'h00;
         shift_r <= '0;
         op_r <= 8'h00;
         addr_r <= '0;
         tx_r <= 8'h00;
         outCnt_r <= 4'h0;
         dummyCnt_r <= 4'h0;
         complete_r <= 1'b0;
         opSeen_r <= 1'b0;
         link.devIoOut <= 4'h0;
         link.devIoOe <= 4'h0;
      end else if (!csLow) begin
         phase_r <= PH_CMD;
         fieldCnt_r <= 6'h00;
         outCnt_r <= 4'h0;
         complete_r <= 1'b0;
         opSeen_r <= 1'b0;
         link.devIoOe <= 4'h0;
      end else if (sclkRise) begin
         shift_r <= shiftNxt;
         fieldCnt_r <= cntNxt;
         case (phase_r)
            PH_CMD: begin
               if (cntNxt == 6'(CMD_BITS)) begin
                  op_r <= shiftNxt[7:0];
                  opSeen_r <= 1'b1;
                  fieldCnt_r <= 6'h00;
                  phase_r <= busy ? PH_DROP : opPhase;
                  complete_r <= !busy && opPhase == PH_TAIL;
               end
            end
            PH_ADDR: begin
               if (cntNxt == 6'(ADDR_BITS)) begin
                  addr_r <= shiftNxt;
                  fieldCnt_r <= 6'h00;
                  if (op_r == OP_READ_LOCK) begin
                     tx_r <= {7'h00, lock_r[lockIdx(shiftNxt)]};
                     phase_r <= PH_DATA;
                  end else if (op_r == OP_WRAP_READ) begin
                     dummyCnt_r <= DUMMY_BASE + {param_r[PARAM_DUMMY_LSB +: 2], 1'b0};
                     phase_r <= PH_DUMMY;
                  end else begin
                     complete_r <= 1'b1;
                     phase_r <= PH_TAIL;
                  end
               end
            end
            PH_PARAM: begin
               if (cntNxt == 6'(PARAM_BITS)) begin
                  complete_r <= 1'b1;
                  phase_r <= PH_TAIL;
               end
            end
            PH_DUMMY: begin
               dummyCnt_r <= dummyCnt_r - 4'h1;
               if (dummyCnt_r == 4'h1) begin
                  tx_r <= addr_r[7:0];
                  phase_r <= PH_DATA;
               end
            end
            PH_TAIL: begin
               // clocks past the last field spoil the command
               complete_r <= 1'b0;
               phase_r <= PH_DROP;
            end
            default: begin
            end
         endcase
      end else if (sclkFall && phase_r == PH_DATA) begin
         link.devIoOut <= qpi_r ? tx_r[7:4] : {2'h0, tx_r[7], 1'b0};
         link.devIoOe <= qpi_r ? 4'hf : 4'h2;
         tx_r <= tx_r << stepBits;
         outCnt_r <= outNxt;
         if (outNxt == 4'(BYTE_BITS)) begin
            outCnt_r <= 4'h0;
            if (op_r == OP_READ_LOCK) begin
               tx_r <= {7'h00, lock_r[lockIdx(addr_r)]};
            end else begin
               addr_r <= addrNxt;
               tx_r <= addrNxt[7:0];
            end
         end
      end
   end

   // mode, latch, parameters and lock bits
   always_ff @(posedge ref_clk) begin
      if (sys_rst || softReset) begin
         qpi_r <= 1'b0;
         wel_r <= 1'b0;
         susp_r <= 1'b0;
         rstEn_r <= 1'b0;
         param_r <= PARAM_RESET;
         lock_r <= '1;
      end else if (csRise && opSeen_r) begin
         rstEn_r <= complete_r && op_r == OP_RESET_EN;
         if (complete_r) begin
            case (op_r)
               OP_WREN: wel_r <= 1'b1;
               OP_WRDI: wel_r <= 1'b0;
               OP_SUSPEND: susp_r <= 1'b1;
               OP_RESUME: susp_r <= 1'b0;
               OP_ENTER_4W: begin
                  if (quadEnableBit) begin
                     qpi_r <= 1'b1;
                  end
               end
               OP_EXIT_4W: qpi_r <= 1'b0;
               OP_SET_PARAM: param_r <= shift_r[PARAM_BITS-1:0];
               OP_LOCK: begin
                  if (wel_r) begin
                     lock_r[lockIdx(addr_r)] <= 1'b1;
                  end
               end
               OP_UNLOCK: begin
                  if (wel_r) begin
                     lock_r[lockIdx(addr_r)] <= 1'b0;
                  end
               end
               OP_GLOBAL_LOCK: begin
                  if (wel_r) begin
                     lock_r <= '1;
                  end
               end
               OP_GLOBAL_UNLOCK: begin
                  if (wel_r) begin
                     lock_r <= '0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busyCnt_r <= '0;
      end else if (softReset) begin
         busyCnt_r <= BUSY_BITS'(RESET_CYCLES);
      end else if (busy) begin
         busyCnt_r <= busyCnt_r - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         protActive <= 1'b1;
         resetBusy <= 1'b0;
      end else begin
         protActive <= protectSchemeSelect ? lock_r[lockIdx(protAddr)]
                       : legacyProt(protAddr, blockProtectField, topBottomSelect,
                                    sectorGranularityBit, protectComplementBit);
         resetBusy <= busy;
      end
   end

   assign fourWireMode = qpi_r;
   assign writeEnableLatch = wel_r;
   assign suspendFlag = susp_r;
endmodule : sfml_device_end

// *** src/sfml_host_end.sv ***
`timescale 1ns/1ps
module sfml_host_end #(
   parameter int HALF_PERIOD = sfml_pkg::SCLK_HALF
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   sfml_link_if.host link,
   input wire logic cmdValid,
   input wire logic [7:0] cmdOp,
   input wire logic [sfml_pkg::ADDR_BITS-1:0] cmdAddr,
   input wire logic cmdAddrEn,
   input wire logic [7:0] cmdParam,
   input wire logic cmdParamEn,
   input wire logic [3:0] cmdDummy,
   input wire logic [7:0] cmdReadBytes,
   input wire logic quadMode,
   output logic busy,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic done
);
   import sfml_pkg::*;

   localparam int HALF_BITS = $clog2(HALF_PERIOD + 1);
   localparam int TX_BITS = CMD_BITS + ADDR_BITS + PARAM_BITS;

   sfml_host_state_type state_r;
   logic [HALF_BITS-1:0] half_r;
   logic [TX_BITS-1:0] tx_r;
   logic [5:0] outLeft_r;
   logic [3:0] dummyLeft_r;
   logic [10:0] inLeft_r;
   logic [7:0] rx_r;
   logic [3:0] rxCnt_r;
   logic quad_r;
   logic [3:0] ioMeta_r;
   logic [3:0] ioSync_r;

   logic [TX_BITS-1:0] txLoad;
   logic [5:0] outBits;
   logic [2:0] stepBits;
   logic [7:0] rxNxt;
   logic [3:0] rxCntNxt;
   logic halfEnd;

   // address follows the opcode, then the parameter byte
   assign txLoad = cmdAddrEn ? {cmdOp, cmdAddr, cmdParam} : {cmdOp, cmdParam, 24'h000000};
   assign outBits = 6'(CMD_BITS) + (cmdAddrEn ? 6'(ADDR_BITS) : 6'h00)
                    + (cmdParamEn ? 6'(PARAM_BITS) : 6'h00);
   assign stepBits = quad_r ? 3'h4 : 3'h1;
   assign rxNxt = quad_r ? {rx_r[3:0], ioSync_r} : {rx_r[6:0], ioSync_r[1]};
   assign rxCntNxt = rxCnt_r + 4'(stepBits);
   assign halfEnd = (half_r == HALF_BITS'(HALF_PERIOD - 1));

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ioMeta_r <= 4'hf;
         ioSync_r <= 4'hf;
      end else begin
         ioMeta_r <= link.ioLevel;
         ioSync_r <= ioMeta_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= H_IDLE;
         half_r <= '0;
         tx_r <= '0;
         outLeft_r <= 6'h00;
         dummyLeft_r <= 4'h0;
         inLeft_r <= 11'h000;
         rx_r <= 8'h00;
         rxCnt_r <= 4'h0;
         quad_r <= 1'b0;
         busy <= 1'b0;
         rdData <= 8'h00;
         rdValid <= 1'b0;
         done <= 1'b0;
         link.csN <= 1'b1;
         link.sclk <= 1'b0;
         link.hostIoOut <= 4'h0;
         link.hostIoOe <= 4'h0;
      end else begin
         rdValid <= 1'b0;
         done <= 1'b0;
         case (state_r)
            H_IDLE: begin
               if (cmdValid) begin
                  state_r <= H_RUN;
                  busy <= 1'b1;
                  half_r <= '0;
                  quad_r <= quadMode;
                  tx_r <= txLoad;
                  outLeft_r <= quadMode ? (outBits >> 2) : outBits;
                  dummyLeft_r <= cmdDummy;
                  inLeft_r <= quadMode ? {2'h0, cmdReadBytes, 1'b0} : {cmdReadBytes, 3'h0};
                  rxCnt_r <= 4'h0;
                  link.csN <= 1'b0;
                  link.hostIoOut <= quadMode ? txLoad[TX_BITS-1 -: 4]
                                             : {3'h0, txLoad[TX_BITS-1]};
                  link.hostIoOe <= quadMode ? 4'hf : 4'h1;
               end
            end
            H_RUN: begin
               half_r <= half_r + 1'b1;
               if (halfEnd) begin
                  half_r <= '0;
                  if (!link.sclk) begin
                     link.sclk <= 1'b1;
                     if (outLeft_r != 6'h00) begin
                        outLeft_r <= outLeft_r - 6'h01;
                        tx_r <= tx_r << stepBits;
                     end else if (dummyLeft_r != 4'h0) begin
                        dummyLeft_r <= dummyLeft_r - 4'h1;
                     end else if (inLeft_r != 11'h000) begin
                        inLeft_r <= inLeft_r - 11'h001;
                        rx_r <= rxNxt;
                        rxCnt_r <= rxCntNxt;
                        if (rxCntNxt == 4'(BYTE_BITS)) begin
                           rxCnt_r <= 4'h0;
                           rdData <= rxNxt;
                           rdValid <= 1'b1;
                        end
                     end
                  end else begin
                     link.sclk <= 1'b0;
                     if (outLeft_r == 6'h00 && dummyLeft_r == 4'h0 && inLeft_r == 11'h000) begin
                        link.csN <= 1'b1;
                        link.hostIoOe <= 4'h0;
                        state_r <= H_GAP;
                     end else if (outLeft_r != 6'h00) begin
                        link.hostIoOut <= quad_r ? tx_r[TX_BITS-1 -: 4]
                                                 : {3'h0, tx_r[TX_BITS-1]};
                     end else begin
                        link.hostIoOe <= 4'h0;
                     end
                  end
               end
            end
            H_GAP: begin
               half_r <= half_r + 1'b1;
               if (halfEnd) begin
                  half_r <= '0;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state_r <= H_IDLE;
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end
endmodule : sfml_host_end

// *** src/sfml_link_if.sv ***
`timescale 1ns/1ps
interface sfml_link_if;
   logic csN;
   logic sclk;
   logic [3:0] hostIoOut;
   logic [3:0] hostIoOe;
   logic [3:0] devIoOut;
   logic [3:0] devIoOe;
   logic [3:0] ioLevel;

   // host wins on contention, undriven lines float high
   assign ioLevel = (hostIoOe & hostIoOut) | (~hostIoOe & devIoOe & devIoOut)
                    | ~(hostIoOe | devIoOe);

   modport host(output csN, output sclk, output hostIoOut, output hostIoOe, input ioLevel);
   modport dev(input csN, input sclk, input ioLevel, output devIoOut, output devIoOe);
endinterface : sfml_link_if

// *** src/sfml_pkg.sv ***
// What this block does
// - wrapped burst read 0Ch wraps in window, four-wire mode only
// - wrap length, dummy clocks from C0h parameters
// - two modes only; 38h enters four-wire
// - power-up starts in serial mode
// - 38h ignored unless quad enable set
// - FFh returns four-wire mode to serial
// - mode switch keeps latch, suspend, wrap
// - lock bits protect only when scheme selected
// - lock bits volatile, all set after reset
// - 36h plus address locks, needs latch
// - 39h plus address unlocks, needs latch
// - 3Dh returns lock byte, lsb locked
// - 7Eh sets all lock bits, needs latch
// - 98h clears all lock bits, needs latch
// - reset needs 66h then 99h directly
// - accepted reset restores power-on defaults
// - commands refused about 30 us after reset
// - host checks busy and suspend first; sfml_host_end sends without checking either
// - defaults: wrap 8 bytes, 2 dummy clocks
package sfml_pkg;
   localparam logic [7:0] OP_WRAP_READ = 8'h0c;
   localparam logic [7:0] OP_SET_PARAM = 8'hc0;
   localparam logic [7:0] OP_ENTER_4W = 8'h38;
   localparam logic [7:0] OP_EXIT_4W = 8'hff;
   localparam logic [7:0] OP_LOCK = 8'h36;
   localparam logic [7:0] OP_UNLOCK = 8'h39;
   localparam logic [7:0] OP_READ_LOCK = 8'h3d;
   localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
   localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
   localparam logic [7:0] OP_RESET_EN = 8'h66;
   localparam logic [7:0] OP_RESET = 8'h99;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;

   localparam int CLK_FREQ_HZ = 20_000_000;
   localparam int RESET_TIME_US = 30;
   localparam int RESET_CYCLES = RESET_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int SCLK_HALF = 8;

   localparam int CMD_BITS = 8;
   localparam int ADDR_BITS = 24;
   localparam int PARAM_BITS = 8;
   localparam int BYTE_BITS = 8;
   localparam logic [PARAM_BITS-1:0] PARAM_RESET = 8'h00;
   localparam int PARAM_WRAP_LSB = 0;
   localparam int PARAM_DUMMY_LSB = 4;
   localparam logic [ADDR_BITS-1:0] WRAP_BASE = 24'h000008;
   localparam logic [3:0] DUMMY_BASE = 4'h2;

   localparam int NUM_LOCKS = 32;
   localparam int BLOCK_LSB = 16;
   localparam int BLOCK_BITS = 5;
   localparam int SECTOR_LSB = 12;
   localparam int SECTOR_BITS = 4;
   localparam logic [6:0] NUM_BLOCKS = 7'h20;
   localparam logic [6:0] SECTORS_PER_BLOCK = 7'h10;

   typedef enum logic [2:0] {
      PH_CMD, PH_ADDR, PH_PARAM, PH_DUMMY, PH_DATA, PH_TAIL, PH_DROP
   } sfml_phase_type;

   typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} sfml_host_state_type;

   function automatic logic [ADDR_BITS-1:0] sfmlWrapNext(input logic [ADDR_BITS-1:0] a,
                                                         input logic [1:0] sel);
      logic [ADDR_BITS-1:0] m;
      m = (WRAP_BASE << sel) - 24'h000001;
      return (a & ~m) | ((a + 24'h000001) & m);
   endfunction : sfmlWrapNext
endpackage : sfml_pkg

// *** tb/serial_flash_mode_lock_reset_bench.sv ***
`timescale 1ns/1ps
module serial_flash_mode_lock_reset_bench;
   import sfml_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmdValid = 1'b0;
   logic [7:0] cmdOp = 8'h00;
   logic [23:0] cmdAddr = 24'h000000;
   logic cmdAddrEn = 1'b0;
   logic [7:0] cmdParam = 8'h00;
   logic cmdParamEn = 1'b0;
   logic [3:0] cmdDummy = 4'h0;
   logic [7:0] cmdReadBytes = 8'h00;
   logic quadMode = 1'b0;
   logic quadEnableBit = 1'b0;
   logic protectSchemeSelect = 1'b1;
   logic protectComplementBit = 1'b0;
   logic [2:0] blockProtectField = 3'h0;
   logic [23:0] protAddr = 24'h000000;
   logic topBottomSelect = 1'b0;
   logic sectorGranularityBit = 1'b0;
   logic busy, rdValid, done, protActive, fourWireMode, writeEnableLatch, suspendFlag, resetBusy;
   logic [7:0] rdData;
   logic [7:0] expQ[$];
   logic [31:0] rngState = 32'h8650;
   logic [23:0] a, b;
   logic [7:0] w;
   int num_errors = 0;
   int cmp_count = 0;
   int n;
   always #25 ref_clk = ~ref_clk;
   sfml_link_if link();
   sfml_host_end sfml_host_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
      .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdAddrEn(cmdAddrEn),
      .cmdParam(cmdParam), .cmdParamEn(cmdParamEn), .cmdDummy(cmdDummy),
      .cmdReadBytes(cmdReadBytes), .quadMode(quadMode), .busy(busy), .rdData(rdData),
      .rdValid(rdValid), .done(done));
   sfml_device_end #(.RESET_CYCLES(400)) sfml_device_end_i (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .link(link), .quadEnableBit(quadEnableBit),
      .protectSchemeSelect(protectSchemeSelect), .protectComplementBit(protectComplementBit),
      .sectorGranularityBit(sectorGranularityBit), .topBottomSelect(topBottomSelect),
      .blockProtectField(blockProtectField), .protAddr(protAddr), .protActive(protActive),
      .fourWireMode(fourWireMode), .writeEnableLatch(writeEnableLatch),
      .suspendFlag(suspendFlag), .resetBusy(resetBusy));
   sfml_link_asserts sfml_link_asserts_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .csN(link.csN), .sclk(link.sclk), .hostIoOut(link.hostIoOut), .hostIoOe(link.hostIoOe),
      .devIoOut(link.devIoOut), .devIoOe(link.devIoOe), .ioLevel(link.ioLevel));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xorshift
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic send(input logic [7:0] op, input logic [23:0] ad, input logic ae,
                       input logic [7:0] pr, input logic [3:0] du, input logic [7:0] nb);
      int k;
      @(posedge ref_clk);
      cmdValid <= 1'b1;
      cmdOp <= op;
      cmdAddr <= ad;
      cmdAddrEn <= ae;
      cmdParam <= pr;
      cmdParamEn <= (op == OP_SET_PARAM);
      cmdDummy <= du;
      cmdReadBytes <= nb;
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
         if (k == 1) check("busy", {7'h0, busy}, 8'h01);
         if (k > 8000) begin
            num_errors++;
            complete_run();
         end
      end while (done !== 1'b1);
   endtask : send
   task automatic cmd(input logic [7:0] op);
      send(op, 24'h000000, 1'b0, 8'h00, 4'h0, 8'h00);
   endtask : cmd
   task automatic readLock(input logic [23:0] ad, input logic [7:0] exp);
      expQ.push_back(exp);
      send(OP_READ_LOCK, ad, 1'b1, 8'h00, 4'h0, 8'h01);
   endtask : readLock
   always @(negedge ref_clk) begin
      if (rdValid === 1'b1) begin
         if (expQ.size() == 0) check("spare byte", {7'h0, rdValid}, 8'h00);
         else check("rdData", rdData, expQ.pop_front());
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      check("mode", {7'h0, fourWireMode}, 8'h00);
      check("prot", {7'h0, protActive}, 8'h01);
      rngState = xorshift(rngState);
      a = {3'h0, rngState[4:0], rngState[15:0]};
      b = a ^ 24'h010000;
      @(posedge ref_clk);
      protAddr <= a;
      readLock(a, 8'h01);
      cmd(OP_GLOBAL_UNLOCK);
      readLock(a, 8'h01);
      cmd(OP_WREN);
      cmd(OP_GLOBAL_UNLOCK);
      readLock(a, 8'h00);
      check("prot", {7'h0, protActive}, 8'h00);
      send(OP_LOCK, a, 1'b1, 8'h00, 4'h0, 8'h00);
      readLock(a, 8'h01);
      readLock(b, 8'h00);
      check("prot", {7'h0, protActive}, 8'h01);
      send(OP_UNLOCK, a, 1'b1, 8'h00, 4'h0, 8'h00);
      readLock(a, 8'h00);
      cmd(OP_GLOBAL_LOCK);
      readLock(b, 8'h01);
      @(posedge ref_clk);
      protectSchemeSelect <= 1'b0;
      repeat (3) @(negedge ref_clk);
      check("legacy", {7'h0, protActive}, 8'h00);
      @(posedge ref_clk);
      protectComplementBit <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check("legacy", {7'h0, protActive}, 8'h01);
      @(posedge ref_clk);
      {protectComplementBit, topBottomSelect, blockProtectField} <= 5'h09;
      protAddr <= 24'h001000;
      repeat (3) @(negedge ref_clk);
      check("legacy", {7'h0, protActive}, 8'h01);
      @(posedge ref_clk);
      sectorGranularityBit <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check("legacy", {7'h0, protActive}, 8'h00);
      @(posedge ref_clk);
      protectSchemeSelect <= 1'b1;
      $display("test locks done");
      cmd(OP_SUSPEND);
      cmd(OP_ENTER_4W);
      check("mode", {7'h0, fourWireMode}, 8'h00);
      @(posedge ref_clk);
      quadEnableBit <= 1'b1;
      cmd(OP_ENTER_4W);
      check("mode", {7'h0, fourWireMode}, 8'h01);
      check("latch", {6'h0, writeEnableLatch, suspendFlag}, 8'h03);
      @(posedge ref_clk);
      quadMode <= 1'b1;
      rngState = xorshift(rngState);
      w = {rngState[7:3], 3'h6};
      for (n = 0; n < 4; n++) expQ.push_back((w & 8'hf8) | ((w + n[7:0]) & 8'h07));
      send(OP_WRAP_READ, {16'h0000, w}, 1'b1, 8'h00, 4'h2, 8'h04);
      send(OP_SET_PARAM, 24'h000000, 1'b0, 8'h11, 4'h0, 8'h00);
      w = {rngState[11:8], 4'he};
      for (n = 0; n < 3; n++) expQ.push_back((w & 8'hf0) | ((w + n[7:0]) & 8'h0f));
      send(OP_WRAP_READ, {16'h0000, w}, 1'b1, 8'h00, 4'h4, 8'h03);
      cmd(OP_EXIT_4W);
      @(posedge ref_clk);
      quadMode <= 1'b0;
      check("mode", {7'h0, fourWireMode}, 8'h00);
      check("latch", {6'h0, writeEnableLatch, suspendFlag}, 8'h03);
      $display("test modes done");
      cmd(OP_RESUME);
      check("susp", {7'h0, suspendFlag}, 8'h00);
      cmd(OP_GLOBAL_UNLOCK);
      cmd(OP_RESET_EN);
      cmd(OP_WREN);
      cmd(OP_RESET);
      readLock(a, 8'h00);
      cmd(OP_RESET_EN);
      cmd(OP_RESET);
      check("rst", {4'h0, resetBusy, writeEnableLatch, suspendFlag, fourWireMode}, 8'h08);
      cmd(OP_WREN);
      check("latch", {7'h0, writeEnableLatch}, 8'h00);
      n = 0;
      while (resetBusy !== 1'b0 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      check("reset time", {7'h0, resetBusy}, 8'h00);
      if (resetBusy !== 1'b0) complete_run();
      readLock(a, 8'h01);
      cmd(OP_WREN);
      check("latch", {7'h0, writeEnableLatch}, 8'h01);
      cmd(OP_WRDI);
      send(OP_UNLOCK, a, 1'b1, 8'h00, 4'h0, 8'h00);
      readLock(a, 8'h01);
      $display("test reset done");
      repeat (4) @(negedge ref_clk);
      check("pending", expQ.size() == 0 ? 8'h00 : 8'h01, 8'h00);
      complete_run();
   end
endmodule : serial_flash_mode_lock_reset_bench

// *** tb/sfml_link_asserts.sv ***
`timescale 1ns/1ps
module sfml_link_asserts (
   input logic ref_clk,
   input logic sys_rst,
   input logic csN,
   input logic sclk,
   input logic [3:0] hostIoOut,
   input logic [3:0] hostIoOe,
   input logic [3:0] devIoOut,
   input logic [3:0] devIoOe,
   input logic [3:0] ioLevel
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_resetIdle;
      $fell(sys_rst) |-> csN && !sclk && hostIoOe == 4'h0 && devIoOe == 4'h0;
   endproperty
   a_resetIdle: assert property (p_resetIdle) else $error("link busy after reset");
   property p_noFight;
      (hostIoOe & devIoOe) == 4'h0;
   endproperty
   a_noFight: assert property (p_noFight) else $error("both ends drive one line");
   property p_devRelease;
      $rose(csN) |-> ##[1:5] devIoOe == 4'h0;
   endproperty
   a_devRelease: assert property (p_devRelease) else $error("device holds line after frame");
   property p_idleClk;
      csN |-> !sclk;
   endproperty
   a_idleClk: assert property (p_idleClk) else $error("clock runs outside frame");
   property p_sclkHigh;
      $rose(sclk) |-> sclk [*8] ##1 !sclk;
   endproperty
   a_sclkHigh: assert property (p_sclkHigh) else $error("clock high phase wrong");
   property p_csHold;
      sclk |-> !csN;
   endproperty
   a_csHold: assert property (p_csHold) else $error("select moved with clock high");
   property p_hostStable;
      sclk && $past(sclk) |-> $stable(hostIoOe) && $stable(hostIoOut);
   endproperty
   a_hostStable: assert property (p_hostStable) else $error("host data moved on high clock");
   property p_devStable;
      sclk && $past(sclk) |-> $stable(devIoOe) && $stable(devIoOut);
   endproperty
   a_devStable: assert property (p_devStable) else $error("device data moved on high clock");
   c_frame: cover property ($rose(csN));
   c_serialRead: cover property (devIoOe == 4'h2);
   c_quadRead: cover property (devIoOe == 4'hf && ioLevel == devIoOut);
endmodule : sfml_link_asserts
